/* design/pgate_pkg.sv */
// Purpose: Shared constants for the peripheral clock gating registers
// Assumes: Classic Wishbone slave, 32-bit data, registers in the low 16 bits
// Notes: Register offsets are byte addresses on the bus
package pgate_pkg;
	// ==========================================================
	// Bus geometry
	localparam int PGATE_ADR_W = 4;
	localparam int PGATE_DAT_W = 32;
	localparam int PGATE_REG_W = 16;
	localparam logic [3:0] PGATE_OFS_FIRST = 4'h0;
	localparam logic [3:0] PGATE_OFS_SECOND = 4'h4;
	// ==========================================================
	// Implemented bits and reset values
	localparam logic [15:0] PGATE_IMPL_FIRST = 16'hf8fb;
	localparam logic [15:0] PGATE_IMPL_SECOND = 16'hc30f;
	localparam logic [15:0] PGATE_RST_VAL = 16'h0000;
	// ==========================================================
	// Field positions, first register
	localparam int PGATE_TIMER5_OFF = 15;
	localparam int PGATE_TIMER4_OFF = 14;
	localparam int PGATE_TIMER3_OFF = 13;
	localparam int PGATE_TIMER2_OFF = 12;
	localparam int PGATE_TIMER1_OFF = 11;
	localparam int PGATE_I2C_PORT_OFF = 7;
	localparam int PGATE_UART_B_OFF = 6;
	localparam int PGATE_UART_A_OFF = 5;
	localparam int PGATE_SPI_B_OFF = 4;
	localparam int PGATE_SPI_A_OFF = 3;
	localparam int PGATE_CAN_CTRL_OFF = 1;
	localparam int PGATE_ADC_OFF = 0;
	// ==========================================================
	// Field positions, second register
	localparam int PGATE_CAPTURE8_OFF = 15;
	localparam int PGATE_CAPTURE7_OFF = 14;
	localparam int PGATE_CAPTURE2_OFF = 9;
	localparam int PGATE_CAPTURE1_OFF = 8;
	localparam int PGATE_COMPARE4_OFF = 3;
	localparam int PGATE_COMPARE3_OFF = 2;
	localparam int PGATE_COMPARE2_OFF = 1;
	localparam int PGATE_COMPARE1_OFF = 0;
	// ==========================================================
	// Timing: gating change lands one instruction cycle after the write
	localparam int PGATE_APPLY_CYCLES = 1;
endpackage

/* design/pgate_gate_if.sv */
// Purpose: Carrier between the bus slave, a gating register and its enable stage
// Assumes: One clock
// Notes: One instance per gating register
`timescale 1ns/10ps
interface pgate_gate_if;
	logic wr_en;
	logic [15:0] wr_data;
	logic [15:0] wr_mask;
	logic [15:0] rd_data;
	logic [15:0] clk_en;
	modport ctl (output wr_en, output wr_data, output wr_mask, input rd_data, input clk_en);
	modport store (input wr_en, input wr_data, input wr_mask, output rd_data);
	modport gate (input rd_data, output clk_en);
endinterface

/* design/pgate_gate_reg.sv */
// Purpose: One 16-bit gating register with lane masked write
// Assumes: Write strobe is one cycle wide
// Notes: Unimplemented bits are never stored
`timescale 1ns/10ps
module pgate_gate_reg import pgate_pkg::*; #(
	parameter logic [15:0] IMPL_MASK = 16'hffff
) (
	input wire logic core_clk,
	input wire logic nrst,
	pgate_gate_if.store gif
);
	logic [15:0] bits_q;
	// ==========================================================
	// Storage
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			bits_q <= PGATE_RST_VAL;
		end else if (gif.wr_en) begin
			bits_q <= ((bits_q & ~gif.wr_mask) | (gif.wr_data & gif.wr_mask)) & IMPL_MASK;
		end
	end
	assign gif.rd_data = bits_q & IMPL_MASK;
endmodule

/* design/pgate_en_stage.sv */
// Purpose: Registered clock enables derived from one gating register
// Assumes: Peripherals gate their clock with a latch cell fed by these enables
// Notes: Registered so the enables never glitch mid-cycle
`timescale 1ns/10ps
module pgate_en_stage import pgate_pkg::*; #(
	parameter logic [15:0] IMPL_MASK = 16'hffff,
	parameter logic [15:0] PRESENT_MASK = 16'hffff
) (
	input wire logic core_clk,
	input wire logic nrst,
	pgate_gate_if.gate gif
);
	logic [15:0] en_q;
	// ==========================================================
	// Enable register, one cycle behind the gating bits
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			en_q <= IMPL_MASK & PRESENT_MASK;
		end else begin
			en_q <= ~gif.rd_data & IMPL_MASK & PRESENT_MASK;
		end
	end
	assign gif.clk_en = en_q;
endmodule

/* design/pgate_top.sv */
// Purpose: Peripheral clock gating registers behind a classic Wishbone slave
// Assumes: core_clk at 10 MHz; one cycle stands for one instruction cycle
// Notes: Enables are active high; a low enable means stopped clock and held reset
// Function
// - First register bits 15..11 stop timers five to one; one stops, zero runs.
// - First register bits 7..3 stop I2C, UART B, UART A, SPI B, SPI A.
// - First register bit 1 stops CAN controller, bit 0 stops the ADC.
// - Second register bits 15,14,9,8 stop capture channels 8,7,2,1.
// - Second register bits 3..0 stop compare channels four to one.
// - Unused bits ignore writes and read zero.
// - Implemented bits are read/write and reset to zero, all present peripherals enabled.
// - A gating change reaches the peripheral one cycle after the write.
// - A gated peripheral ignores register writes; its reads are undefined.
// - Enable only when the bit is zero and the peripheral exists.
`timescale 1ns/10ps
module pgate_top import pgate_pkg::*; #(
	parameter logic [15:0] PRESENT_FIRST = 16'hf8fb,
	parameter logic [15:0] PRESENT_SECOND = 16'hc30f
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [PGATE_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [PGATE_DAT_W-1:0] wb_dat_i,
	output logic [PGATE_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic timer5_clk_en,
	output logic timer4_clk_en,
	output logic timer3_clk_en,
	output logic timer2_clk_en,
	output logic timer1_clk_en,
	output logic i2c_port_clk_en,
	output logic uart_b_clk_en,
	output logic uart_a_clk_en,
	output logic spi_b_clk_en,
	output logic spi_a_clk_en,
	output logic can_ctrl_clk_en,
	output logic adc_clk_en,
	output logic capture8_clk_en,
	output logic capture7_clk_en,
	output logic capture2_clk_en,
	output logic capture1_clk_en,
	output logic compare4_clk_en,
	output logic compare3_clk_en,
	output logic compare2_clk_en,
	output logic compare1_clk_en
);
	logic ack_q;
	logic [PGATE_DAT_W-1:0] dat_q;
	logic req;
	logic hit_first;
	logic hit_second;
	logic [15:0] lane_mask;
	logic [15:0] rd_mux;
	pgate_gate_if gif_first ();
	pgate_gate_if gif_second ();

	// ==========================================================
	// Bus decode
	assign req = wb_cyc_i & wb_stb_i;
	assign hit_first = (wb_adr_i == PGATE_OFS_FIRST);
	assign hit_second = (wb_adr_i == PGATE_OFS_SECOND);
	assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// Write lands on the edge where the master sees ack, as classic Wishbone expects
	assign gif_first.wr_en = req & wb_we_i & ack_q & hit_first;
	assign gif_first.wr_data = wb_dat_i[15:0];
	assign gif_first.wr_mask = lane_mask;
	assign gif_second.wr_en = req & wb_we_i & ack_q & hit_second;
	assign gif_second.wr_data = wb_dat_i[15:0];
	assign gif_second.wr_mask = lane_mask;

	always_comb begin
		rd_mux = 16'h0000;
		if (hit_first) begin
			rd_mux = gif_first.rd_data;
		end else if (hit_second) begin
			rd_mux = gif_second.rd_data;
		end
	end

	// ==========================================================
	// Ack and read data; unmapped addresses ack and read zero
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			dat_q <= 32'h00000000;
		end else if (req & ~ack_q) begin
			dat_q <= {16'h0000, rd_mux};
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// ==========================================================
	// Register and enable stages
	pgate_gate_reg #(
		.IMPL_MASK(PGATE_IMPL_FIRST)
	) u_reg_first (
		.core_clk(core_clk),
		.nrst(nrst),
		.gif(gif_first)
	);

	pgate_gate_reg #(
		.IMPL_MASK(PGATE_IMPL_SECOND)
	) u_reg_second (
		.core_clk(core_clk),
		.nrst(nrst),
		.gif(gif_second)
	);

	// Absent peripherals keep their enable low whatever software writes
	pgate_en_stage #(
		.IMPL_MASK(PGATE_IMPL_FIRST),
		.PRESENT_MASK(PRESENT_FIRST)
	) u_en_first (
		.core_clk(core_clk),
		.nrst(nrst),
		.gif(gif_first)
	);

	pgate_en_stage #(
		.IMPL_MASK(PGATE_IMPL_SECOND),
		.PRESENT_MASK(PRESENT_SECOND)
	) u_en_second (
		.core_clk(core_clk),
		.nrst(nrst),
		.gif(gif_second)
	);

	// ==========================================================
	// Per-peripheral enables; a low enable also blocks its register writes
	assign timer5_clk_en = gif_first.clk_en[PGATE_TIMER5_OFF];
	assign timer4_clk_en = gif_first.clk_en[PGATE_TIMER4_OFF];
	assign timer3_clk_en = gif_first.clk_en[PGATE_TIMER3_OFF];
	assign timer2_clk_en = gif_first.clk_en[PGATE_TIMER2_OFF];
	assign timer1_clk_en = gif_first.clk_en[PGATE_TIMER1_OFF];
	assign i2c_port_clk_en = gif_first.clk_en[PGATE_I2C_PORT_OFF];
	assign uart_b_clk_en = gif_first.clk_en[PGATE_UART_B_OFF];
	assign uart_a_clk_en = gif_first.clk_en[PGATE_UART_A_OFF];
	assign spi_b_clk_en = gif_first.clk_en[PGATE_SPI_B_OFF];
	assign spi_a_clk_en = gif_first.clk_en[PGATE_SPI_A_OFF];
	assign can_ctrl_clk_en = gif_first.clk_en[PGATE_CAN_CTRL_OFF];
	assign adc_clk_en = gif_first.clk_en[PGATE_ADC_OFF];
	assign capture8_clk_en = gif_second.clk_en[PGATE_CAPTURE8_OFF];
	assign capture7_clk_en = gif_second.clk_en[PGATE_CAPTURE7_OFF];
	assign capture2_clk_en = gif_second.clk_en[PGATE_CAPTURE2_OFF];
	assign capture1_clk_en = gif_second.clk_en[PGATE_CAPTURE1_OFF];
	assign compare4_clk_en = gif_second.clk_en[PGATE_COMPARE4_OFF];
	assign compare3_clk_en = gif_second.clk_en[PGATE_COMPARE3_OFF];
	assign compare2_clk_en = gif_second.clk_en[PGATE_COMPARE2_OFF];
	assign compare1_clk_en = gif_second.clk_en[PGATE_COMPARE1_OFF];

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	logic past_valid_q;
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			past_valid_q <= 1'b0;
		end else begin
			past_valid_q <= 1'b1;
		end
	end

	a_timer5_follow: assert property (
		gif_first.wr_en && wb_sel_i[1] |-> ##2 timer5_clk_en == (!$past(wb_dat_i[15], 2) && PRESENT_FIRST[15]))
		else $error("timer5 enable does not follow written bit");

	a_spi_a_follow: assert property (
		gif_first.wr_en && wb_sel_i[0] |-> ##2 spi_a_clk_en == (!$past(wb_dat_i[3], 2) && PRESENT_FIRST[3]))
		else $error("spi a enable does not follow written bit");

	a_adc_follow: assert property (
		gif_first.wr_en && wb_sel_i[0] |-> ##2 adc_clk_en == (!$past(wb_dat_i[0], 2) && PRESENT_FIRST[0]))
		else $error("adc enable does not follow written bit");

	a_capture7_follow: assert property (
		gif_second.wr_en && wb_sel_i[1] |-> ##2 capture7_clk_en == (!$past(wb_dat_i[14], 2) && PRESENT_SECOND[14]))
		else $error("capture7 enable does not follow written bit");

	a_compare4_follow: assert property (
		gif_second.wr_en && wb_sel_i[0] |-> ##2 compare4_clk_en == (!$past(wb_dat_i[3], 2) && PRESENT_SECOND[3]))
		else $error("compare4 enable does not follow written bit");

	a_timer4_follow: assert property (
		gif_first.wr_en && wb_sel_i[1] |-> ##2 timer4_clk_en == (!$past(wb_dat_i[14], 2) && PRESENT_FIRST[14]))
		else $error("timer4 enable does not follow written bit");

	a_timer3_follow: assert property (
		gif_first.wr_en && wb_sel_i[1] |-> ##2 timer3_clk_en == (!$past(wb_dat_i[13], 2) && PRESENT_FIRST[13]))
		else $error("timer3 enable does not follow written bit");

	a_timer2_follow: assert property (
		gif_first.wr_en && wb_sel_i[1] |-> ##2 timer2_clk_en == (!$past(wb_dat_i[12], 2) && PRESENT_FIRST[12]))
		else $error("timer2 enable does not follow written bit");

	a_timer1_follow: assert property (
		gif_first.wr_en && wb_sel_i[1] |-> ##2 timer1_clk_en == (!$past(wb_dat_i[11], 2) && PRESENT_FIRST[11]))
		else $error("timer1 enable does not follow written bit");

	a_i2c_port_follow: assert property (
		gif_first.wr_en && wb_sel_i[0] |-> ##2 i2c_port_clk_en == (!$past(wb_dat_i[7], 2) && PRESENT_FIRST[7]))
		else $error("i2c port enable does not follow written bit");

	a_uart_b_follow: assert property (
		gif_first.wr_en && wb_sel_i[0] |-> ##2 uart_b_clk_en == (!$past(wb_dat_i[6], 2) && PRESENT_FIRST[6]))
		else $error("uart b enable does not follow written bit");

	a_uart_a_follow: assert property (
		gif_first.wr_en && wb_sel_i[0] |-> ##2 uart_a_clk_en == (!$past(wb_dat_i[5], 2) && PRESENT_FIRST[5]))
		else $error("uart a enable does not follow written bit");

	a_spi_b_follow: assert property (
		gif_first.wr_en && wb_sel_i[0] |-> ##2 spi_b_clk_en == (!$past(wb_dat_i[4], 2) && PRESENT_FIRST[4]))
		else $error("spi b enable does not follow written bit");

	a_can_ctrl_follow: assert property (
		gif_first.wr_en && wb_sel_i[0] |-> ##2 can_ctrl_clk_en == (!$past(wb_dat_i[1], 2) && PRESENT_FIRST[1]))
		else $error("can controller enable does not follow written bit");

	a_capture8_follow: assert property (
		gif_second.wr_en && wb_sel_i[1] |-> ##2 capture8_clk_en == (!$past(wb_dat_i[15], 2) && PRESENT_SECOND[15]))
		else $error("capture8 enable does not follow written bit");

	a_capture2_follow: assert property (
		gif_second.wr_en && wb_sel_i[1] |-> ##2 capture2_clk_en == (!$past(wb_dat_i[9], 2) && PRESENT_SECOND[9]))
		else $error("capture2 enable does not follow written bit");

	a_capture1_follow: assert property (
		gif_second.wr_en && wb_sel_i[1] |-> ##2 capture1_clk_en == (!$past(wb_dat_i[8], 2) && PRESENT_SECOND[8]))
		else $error("capture1 enable does not follow written bit");

	a_compare3_follow: assert property (
		gif_second.wr_en && wb_sel_i[0] |-> ##2 compare3_clk_en == (!$past(wb_dat_i[2], 2) && PRESENT_SECOND[2]))
		else $error("compare3 enable does not follow written bit");

	a_compare2_follow: assert property (
		gif_second.wr_en && wb_sel_i[0] |-> ##2 compare2_clk_en == (!$past(wb_dat_i[1], 2) && PRESENT_SECOND[1]))
		else $error("compare2 enable does not follow written bit");

	a_compare1_follow: assert property (
		gif_second.wr_en && wb_sel_i[0] |-> ##2 compare1_clk_en == (!$past(wb_dat_i[0], 2) && PRESENT_SECOND[0]))
		else $error("compare1 enable does not follow written bit");

	a_unused_zero: assert property (
		wb_ack_o && !wb_we_i |-> (wb_dat_o[31:16] == 16'h0000) &&
			(hit_first ? (wb_dat_o[10:8] == 3'h0 && !wb_dat_o[2]) :
			hit_second ? (wb_dat_o[13:10] == 4'h0 && wb_dat_o[7:4] == 4'h0) : (wb_dat_o == 32'h00000000)))
		else $error("unused bits read nonzero");

	a_readback_write: assert property (
		gif_second.wr_en && (wb_sel_i[1:0] == 2'h3) |=> gif_second.rd_data == ($past(wb_dat_i[15:0]) & PGATE_IMPL_SECOND))
		else $error("second register readback mismatch");

	a_reset_enabled: assert property (
		!past_valid_q |-> gif_first.rd_data == 16'h0000 && gif_second.rd_data == 16'h0000)
		else $error("gating bits not clear after reset");

	a_apply_delay: assert property (
		gif_first.wr_en |=> $stable(gif_first.clk_en))
		else $error("enable changed in the same cycle as the write");

	a_absent_off: assert property (
		(gif_first.clk_en & ~PRESENT_FIRST) == 16'h0000 && (gif_second.clk_en & ~PRESENT_SECOND) == 16'h0000)
		else $error("absent peripheral enabled");

	a_enable_tracks: assert property (
		past_valid_q |-> gif_first.clk_en == (~$past(gif_first.rd_data) & PGATE_IMPL_FIRST & PRESENT_FIRST))
		else $error("first enables not one cycle behind gating bits");

	a_second_tracks: assert property (
		past_valid_q |-> gif_second.clk_en == (~$past(gif_second.rd_data) & PGATE_IMPL_SECOND & PRESENT_SECOND))
		else $error("second enables not one cycle behind gating bits");

	a_readback_first: assert property (
		gif_first.wr_en && (wb_sel_i[1:0] == 2'h3) |=> gif_first.rd_data == ($past(wb_dat_i[15:0]) & PGATE_IMPL_FIRST))
		else $error("first register readback mismatch");

	// Unmapped writes still ack, so nothing else shows that they went nowhere
	a_unmapped_ignored: assert property (
		wb_ack_o && wb_we_i && !hit_first && !hit_second |=> $stable(gif_first.rd_data) && $stable(gif_second.rd_data))
		else $error("unmapped write changed a gating register");

	a_ack_single: assert property (
		req && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle pulse");

	c_gate_timer: cover property (gif_first.wr_en && wb_dat_i[15] ##2 !timer5_clk_en);
	c_regate_timer: cover property (!timer5_clk_en ##[1:20] timer5_clk_en);
	c_gate_compare: cover property (gif_second.wr_en && wb_dat_i[0] ##2 !compare1_clk_en);
	c_unmapped_read: cover property (wb_ack_o && !wb_we_i && !hit_first && !hit_second);
endmodule

/* test/testbench.sv */
// Purpose: Self-checking bench for the peripheral clock gating registers
// Assumes: Wishbone ack within 20 cycles of request; enables move one cycle after the register
// Notes: Two peripherals are made absent to show their enables stay low
`timescale 1ns/10ps
module testbench import pgate_pkg::*; ;
	// ==========================================================
	// Signals
	// Uart b and capture 2 absent; the assertions also follow those two and expect their enables low
	localparam logic [15:0] PRES1 = 16'hf8bb;
	localparam logic [15:0] PRES2 = 16'hc10f;
	typedef struct packed {logic [3:0] adr; logic [3:0] sel; logic [31:0] dat; logic [31:0] rd;} pgate_row_type;
	logic core_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic t5, t4, t3, t2, t1, i2c, ub, ua, sb, sa, can, adc, c8, c7, c2, c1, o4, o3, o2, o1;
	logic [15:0] m1, m2, en1, en2;
	int errors, total_checks;
	pgate_row_type rows [10];
	assign en1 = {t5, t4, t3, t2, t1, 3'h0, i2c, ub, ua, sb, sa, 1'h0, can, adc};
	assign en2 = {c8, c7, 4'h0, c2, c1, 4'h0, o4, o3, o2, o1};
	pgate_top #(.PRESENT_FIRST(PRES1), .PRESENT_SECOND(PRES2)) i_dut (
		.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.timer5_clk_en(t5), .timer4_clk_en(t4), .timer3_clk_en(t3), .timer2_clk_en(t2), .timer1_clk_en(t1),
		.i2c_port_clk_en(i2c), .uart_b_clk_en(ub), .uart_a_clk_en(ua), .spi_b_clk_en(sb), .spi_a_clk_en(sa),
		.can_ctrl_clk_en(can), .adc_clk_en(adc), .capture8_clk_en(c8), .capture7_clk_en(c7),
		.capture2_clk_en(c2), .capture1_clk_en(c1), .compare4_clk_en(o4), .compare3_clk_en(o3),
		.compare2_clk_en(o2), .compare1_clk_en(o1)
	);
	// ==========================================================
	// Checks and verdict
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_en(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: enables %h expected %h", $time, got, exp);
		end
	endtask
	// Enable is on only when the bit is clear, the bit exists and the unit is present
	function automatic logic [15:0] exp_en(input logic [15:0] m, input logic [15:0] impl, input logic [15:0] pres);
		return ~m & impl & pres;
	endfunction
	// ==========================================================
	// Bus master: holds the request until ack is sampled, no fixed latency assumed
	task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] dat);
		int n;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			errors++;
			$display("Error at %0t: ack %h expected %h", $time, wb_ack_o, 1'b1);
			end_of_test();
		end
	endtask
	task automatic check_idle;
		wb_cycle(1'b0, PGATE_OFS_FIRST, 4'hf, 32'h0);
		chk_dat(rd, 32'h0);
		wb_cycle(1'b0, PGATE_OFS_SECOND, 4'hf, 32'h0);
		chk_dat(rd, 32'h0);
		#1;
		chk_en(en1, PRES1 & PGATE_IMPL_FIRST);
		chk_en(en2, PRES2 & PGATE_IMPL_SECOND);
	endtask
	// ==========================================================
	// Clock and stimulus
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		nrst = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		errors = 0;
		total_checks = 0;
		// Sel 4'hc and offset 8 must change nothing
		rows = '{'{4'h0, 4'h3, 32'h0000ffff, 32'h0000f8fb}, '{4'h4, 4'h3, 32'hffffffff, 32'h0000c30f},
			'{4'h0, 4'h1, 32'h00000000, 32'h0000f800}, '{4'h4, 4'h2, 32'h00000000, 32'h0000000f},
			'{4'h0, 4'h3, 32'h0000a5a5, 32'h0000a0a1}, '{4'h4, 4'h3, 32'h00005a5a, 32'h0000420a},
			'{4'h8, 4'h3, 32'h0000ffff, 32'h00000000}, '{4'h0, 4'hc, 32'hffff0000, 32'h0000a0a1},
			'{4'h0, 4'h3, 32'h00000000, 32'h00000000}, '{4'h4, 4'h3, 32'h00000000, 32'h00000000}};
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		check_idle();
		$display("test reset values done");
		m1 = 16'h0;
		m2 = 16'h0;
		for (int i = 0; i < 10; i++) begin
			wb_cycle(1'b1, rows[i].adr, rows[i].sel, rows[i].dat);
			#1;
			chk_en(en1, exp_en(m1, PGATE_IMPL_FIRST, PRES1));
			chk_en(en2, exp_en(m2, PGATE_IMPL_SECOND, PRES2));
			if (rows[i].adr == PGATE_OFS_FIRST)
				m1 = rows[i].rd[15:0];
			else if (rows[i].adr == PGATE_OFS_SECOND)
				m2 = rows[i].rd[15:0];
			@(posedge core_clk);
			#1;
			chk_en(en1, exp_en(m1, PGATE_IMPL_FIRST, PRES1));
			chk_en(en2, exp_en(m2, PGATE_IMPL_SECOND, PRES2));
			wb_cycle(1'b0, rows[i].adr, 4'hf, 32'h0);
			chk_dat(rd, rows[i].rd);
		end
		$display("test register table done");
		// Reset in mid-run with every bit set must bring all present enables back
		wb_cycle(1'b1, PGATE_OFS_FIRST, 4'h3, 32'h0000ffff);
		wb_cycle(1'b1, PGATE_OFS_SECOND, 4'h3, 32'h0000ffff);
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		check_idle();
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule
